// *** rtl/rhc_pkg.sv ***
// constants, register indices and state types of the receive header capture bank
package rhc_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   // register indices; the byte address is four times the index
   localparam logic [7:0] IDX_MASK1 = 8'h45;
   localparam logic [7:0] IDX_MASK0 = 8'h46;
   localparam logic [7:0] IDX_HDR3 = 8'h47;
   localparam logic [7:0] IDX_HDR2 = 8'h48;
   localparam logic [7:0] IDX_HDR1 = 8'h49;
   localparam logic [7:0] IDX_HDR0 = 8'h4A;
   localparam logic [7:0] IDX_RXLEN = 8'h4B;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [31:0] HDR_RST = 32'h0000_0000;
   localparam logic [7:0] LEN_RST = 8'hFF;
   // header byte index of the last byte on air (byte 3 arrives first)
   localparam logic [1:0] HDR_LAST_IDX = 2'h0;
   localparam logic [23:0] RD_PAD = 24'h00_0000;

   typedef struct packed {
      logic [7:0] mask1;
      logic [7:0] mask0;
      logic [31:0] hdr;
      logic [7:0] len;
      logic [7:0] eff_len;
      logic cmp_go;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } rhc_state_t;

   localparam rhc_state_t RST_STATE = '{
      mask1: MASK_RST, mask0: MASK_RST, hdr: HDR_RST, len: LEN_RST,
      eff_len: LEN_RST, cmp_go: 1'b0, prdata: 32'h0000_0000,
      pready: 1'b0, pslverr: 1'b0};

   typedef struct packed {
      logic match;
      logic done;
   } rhc_match_state_t;

   function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
      addr_of = {2'h0, idx, 2'h0};
   endfunction
endpackage

// *** rtl/rhc_match_if.sv ***
// carrier between the register bank and the header comparator
interface rhc_match_if;
   logic [31:0] rx_hdr;
   logic [31:0] chk_hdr;
   logic [31:0] mask;
   logic chk_en;
   logic start;
   logic match;
   logic done;
   modport req (output rx_hdr, output chk_hdr, output mask, output chk_en, output start,
      input match, input done);
   modport cmp (input rx_hdr, input chk_hdr, input mask, input chk_en, input start,
      output match, output done);
endinterface

// *** rtl/rhc_hdr_match.sv ***
// masked comparison of a received header against the expected header
module rhc_hdr_match (
   input wire logic clk_i,
   input wire logic rst_i,
   rhc_match_if.cmp m
);
   rhc_pkg::rhc_match_state_t st_r;
   rhc_pkg::rhc_match_state_t st_nxt;
   logic diff;

   // only bits whose mask bit is 1 take part
   assign diff = |((m.rx_hdr ^ m.chk_hdr) & m.mask);

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = m.start;
      if (m.start) begin
         // check disabled: every header is accepted
         st_nxt.match = ~m.chk_en | ~diff;
      end
      if (rst_i) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   assign m.match = st_r.match;
   assign m.done = st_r.done;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_masked_equal: assert property (m.start && m.chk_en && !diff |=> m.match && m.done)
      else $error("masked equal header not accepted");
   a_masked_differ: assert property (m.start && m.chk_en && diff |=> !m.match)
      else $error("masked differing header accepted");
   a_check_disabled: assert property (m.start && !m.chk_en |=> m.match)
      else $error("header rejected while check disabled");
endmodule

// *** rtl/rhc_regs.sv ***
// receive header capture register bank with apb slave port
// How it works
// - mask byte one, read-write, resets zero
// - mask byte zero, read-write, resets zero
// - header bytes read high byte first
// - middle header bytes zero after reset
// - length register resets all ones, read-only
// - variable length loads received length byte
// - fixed length leaves length register untouched
// - only mask-one bits are compared
// - compare only when header check enabled
// - fixed length uses programmed length byte
module rhc_regs (
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // receive path of the packet handler
   input wire logic RX_HDR_VALID_I,
   input wire logic [1:0] RX_HDR_IDX_I,
   input wire logic [7:0] RX_HDR_BYTE_I,
   input wire logic RX_LEN_VALID_I,
   input wire logic [7:0] RX_LEN_BYTE_I,
   // packet handler configuration held elsewhere
   input wire logic FIX_LEN_I,
   input wire logic [7:0] PROG_LEN_I,
   input wire logic HDR_CHK_EN_I,
   input wire logic [31:0] CHK_HDR_I,
   input wire logic [15:0] HDR_MASK_HI_I,
   // results
   output logic [7:0] RX_LEN_O,
   output logic HDR_DONE_O,
   output logic HDR_MATCH_O
);
   rhc_pkg::rhc_state_t st_r;
   rhc_pkg::rhc_state_t st_nxt;
   logic acc_wr;
   logic acc_done;

   rhc_match_if mif ();

   function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
      hit = (a == rhc_pkg::addr_of(idx));
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = hit(a, rhc_pkg::IDX_MASK1) | hit(a, rhc_pkg::IDX_MASK0)
         | hit(a, rhc_pkg::IDX_HDR3) | hit(a, rhc_pkg::IDX_HDR2)
         | hit(a, rhc_pkg::IDX_HDR1) | hit(a, rhc_pkg::IDX_HDR0)
         | hit(a, rhc_pkg::IDX_RXLEN);
   endfunction

   function automatic logic [7:0] rd_byte(input logic [11:0] a, input rhc_pkg::rhc_state_t s);
      rd_byte = 8'h00;
      if (hit(a, rhc_pkg::IDX_MASK1)) rd_byte = s.mask1;
      if (hit(a, rhc_pkg::IDX_MASK0)) rd_byte = s.mask0;
      if (hit(a, rhc_pkg::IDX_HDR3)) rd_byte = s.hdr[31:24];
      if (hit(a, rhc_pkg::IDX_HDR2)) rd_byte = s.hdr[23:16];
      if (hit(a, rhc_pkg::IDX_HDR1)) rd_byte = s.hdr[15:8];
      if (hit(a, rhc_pkg::IDX_HDR0)) rd_byte = s.hdr[7:0];
      if (hit(a, rhc_pkg::IDX_RXLEN)) rd_byte = s.len;
   endfunction

   // every access is answered in its first access cycle
   assign acc_done = PSEL_I & PENABLE_I & st_r.pready;
   assign acc_wr = acc_done & PWRITE_I;

   always_comb begin
      st_nxt = st_r;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.cmp_go = 1'b0;
      if (PSEL_I & ~PENABLE_I) begin
         st_nxt.pready = 1'b1;
         st_nxt.pslverr = ~mapped(PADDR_I);
         st_nxt.prdata = {rhc_pkg::RD_PAD, rd_byte(PADDR_I, st_r)};
      end
      // writes to read-only registers are silently dropped
      if (acc_wr && hit(PADDR_I, rhc_pkg::IDX_MASK1)) begin
         st_nxt.mask1 = PWDATA_I[7:0];
      end
      if (acc_wr && hit(PADDR_I, rhc_pkg::IDX_MASK0)) begin
         st_nxt.mask0 = PWDATA_I[7:0];
      end
      if (RX_HDR_VALID_I) begin
         st_nxt.hdr[{RX_HDR_IDX_I, 3'b000} +: 8] = RX_HDR_BYTE_I;
         // compare once the last header byte has landed
         st_nxt.cmp_go = (RX_HDR_IDX_I == rhc_pkg::HDR_LAST_IDX);
      end
      if (RX_LEN_VALID_I && !FIX_LEN_I) begin
         st_nxt.len = RX_LEN_BYTE_I;
      end
      st_nxt.eff_len = FIX_LEN_I ? PROG_LEN_I : st_nxt.len;
      if (RST_I) begin
         st_nxt = rhc_pkg::RST_STATE;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      st_r <= st_nxt;
   end

   assign mif.rx_hdr = st_r.hdr;
   assign mif.chk_hdr = CHK_HDR_I;
   assign mif.mask = {HDR_MASK_HI_I, st_r.mask1, st_r.mask0};
   assign mif.chk_en = HDR_CHK_EN_I;
   assign mif.start = st_r.cmp_go;

   rhc_hdr_match u_match (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .m(mif.cmp)
   );

   assign PRDATA_O = st_r.prdata;
   assign PREADY_O = st_r.pready;
   assign PSLVERR_O = st_r.pslverr;
   assign RX_LEN_O = st_r.eff_len;
   assign HDR_DONE_O = mif.done;
   assign HDR_MATCH_O = mif.match;

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);

   sequence s_setup(logic [7:0] idx);
      PSEL_I && !PENABLE_I && hit(PADDR_I, idx) && !PWRITE_I;
   endsequence
   sequence s_access;
      PSEL_I && PENABLE_I && PREADY_O;
   endsequence

   a_mask1_write: assert property (acc_wr && hit(PADDR_I, rhc_pkg::IDX_MASK1)
      |=> st_r.mask1 == $past(PWDATA_I[7:0]))
      else $error("mask byte one not written");
   a_mask0_write: assert property (acc_wr && hit(PADDR_I, rhc_pkg::IDX_MASK0)
      |=> st_r.mask0 == $past(PWDATA_I[7:0]))
      else $error("mask byte zero not written");
   a_hdr_high_read: assert property (s_setup(rhc_pkg::IDX_HDR3) ##0 !RX_HDR_VALID_I ##1 s_access
      |-> PRDATA_O == {rhc_pkg::RD_PAD, st_r.hdr[31:24]})
      else $error("high header byte read wrong");
   a_hdr_mid_reset: assert property ($fell(RST_I) |-> st_r.hdr[23:8] == 16'h0000)
      else $error("middle header bytes not zero after reset");
   a_len_reset: assert property ($fell(RST_I) |-> st_r.len == rhc_pkg::LEN_RST)
      else $error("length not all ones after reset");
   a_len_read_only: assert property (acc_wr && !RX_LEN_VALID_I |=> $stable(st_r.len))
      else $error("length changed by software write");
   a_len_load: assert property (RX_LEN_VALID_I && !FIX_LEN_I
      |=> st_r.len == $past(RX_LEN_BYTE_I) ##0 RX_LEN_O == st_r.len)
      else $error("received length not loaded");
   a_len_fixed_hold: assert property (RX_LEN_VALID_I && FIX_LEN_I |=> $stable(st_r.len))
      else $error("length loaded in fixed mode");
   a_fixed_len_out: assert property (FIX_LEN_I |=> RX_LEN_O == $past(PROG_LEN_I))
      else $error("fixed length not reported");
   a_hdr_capture: assert property (RX_HDR_VALID_I && RX_HDR_IDX_I == rhc_pkg::HDR_LAST_IDX
      |=> st_r.hdr[7:0] == $past(RX_HDR_BYTE_I) ##1 HDR_DONE_O)
      else $error("header byte not captured or compare missing");

   // bus handshake: zero wait states, error only on unmapped words
   a_ready_after_setup: assert property (
      PSEL_I && !PENABLE_I
      |=> PREADY_O)
      else $error("ready missing in first access cycle");
   a_ready_only_setup: assert property (
      !(PSEL_I && !PENABLE_I)
      |=> !PREADY_O)
      else $error("ready raised without setup");
   a_err_unmapped: assert property (
      PSEL_I && !PENABLE_I && !mapped(PADDR_I)
      |=> PSLVERR_O && PRDATA_O == 32'h0000_0000)
      else $error("unmapped word not refused");
   a_err_mapped: assert property (
      PSEL_I && !PENABLE_I && mapped(PADDR_I)
      |=> !PSLVERR_O)
      else $error("mapped word refused");
   a_err_with_ready: assert property (
      PSLVERR_O
      |-> PREADY_O)
      else $error("error raised outside access");
   a_rd_pad: assert property (
      PREADY_O
      |-> PRDATA_O[31:8] == rhc_pkg::RD_PAD)
      else $error("upper read bits not zero");
   a_prdata_hold: assert property (
      !(PSEL_I && !PENABLE_I)
      |=> $stable(PRDATA_O))
      else $error("read data moved outside setup");

   // read data is the register as it stood in the setup cycle
   a_mask1_read: assert property (
      s_setup(rhc_pkg::IDX_MASK1) ##1 s_access
      |-> PRDATA_O[7:0] == $past(st_r.mask1))
      else $error("mask byte one read wrong");
   a_mask0_read: assert property (
      s_setup(rhc_pkg::IDX_MASK0) ##1 s_access
      |-> PRDATA_O[7:0] == $past(st_r.mask0))
      else $error("mask byte zero read wrong");
   a_hdr2_read: assert property (
      s_setup(rhc_pkg::IDX_HDR2) ##1 s_access
      |-> PRDATA_O[7:0] == $past(st_r.hdr[23:16]))
      else $error("header byte two read wrong");
   a_hdr1_read: assert property (
      s_setup(rhc_pkg::IDX_HDR1) ##1 s_access
      |-> PRDATA_O[7:0] == $past(st_r.hdr[15:8]))
      else $error("header byte one read wrong");
   a_hdr0_read: assert property (
      s_setup(rhc_pkg::IDX_HDR0) ##1 s_access
      |-> PRDATA_O[7:0] == $past(st_r.hdr[7:0]))
      else $error("header byte zero read wrong");
   a_len_read: assert property (
      s_setup(rhc_pkg::IDX_RXLEN) ##1 s_access
      |-> PRDATA_O[7:0] == $past(st_r.len))
      else $error("length read wrong");

   // registers move only on their own write or capture strobe
   a_mask1_hold: assert property (
      !(acc_wr && hit(PADDR_I, rhc_pkg::IDX_MASK1))
      |=> $stable(st_r.mask1))
      else $error("mask byte one changed unasked");
   a_mask0_hold: assert property (
      !(acc_wr && hit(PADDR_I, rhc_pkg::IDX_MASK0))
      |=> $stable(st_r.mask0))
      else $error("mask byte zero changed unasked");
   a_hdr_hold: assert property (
      !RX_HDR_VALID_I
      |=> $stable(st_r.hdr))
      else $error("header changed without strobe");
   a_len_hold: assert property (
      !(RX_LEN_VALID_I && !FIX_LEN_I)
      |=> $stable(st_r.len))
      else $error("length changed without strobe");
   a_hdr3_ro: assert property (
      acc_wr && hit(PADDR_I, rhc_pkg::IDX_HDR3) && !RX_HDR_VALID_I
      |=> $stable(st_r.hdr))
      else $error("header byte three written by software");
   a_hdr0_ro: assert property (
      acc_wr && hit(PADDR_I, rhc_pkg::IDX_HDR0) && !RX_HDR_VALID_I
      |=> $stable(st_r.hdr))
      else $error("header byte zero written by software");
   a_len_ro_write: assert property (
      acc_wr && hit(PADDR_I, rhc_pkg::IDX_RXLEN) && !RX_LEN_VALID_I
      |=> $stable(st_r.len))
      else $error("length written by software");

   // capture path and comparator hand-off
   a_hdr_byte_load: assert property (
      RX_HDR_VALID_I
      |=> st_r.hdr[{$past(RX_HDR_IDX_I), 3'b000} +: 8] == $past(RX_HDR_BYTE_I))
      else $error("header byte landed in wrong slot");
   a_cmp_start: assert property (
      RX_HDR_VALID_I && RX_HDR_IDX_I == rhc_pkg::HDR_LAST_IDX
      |=> st_r.cmp_go)
      else $error("compare not started on last byte");
   a_cmp_quiet: assert property (
      !(RX_HDR_VALID_I && RX_HDR_IDX_I == rhc_pkg::HDR_LAST_IDX)
      |=> !st_r.cmp_go)
      else $error("compare started early");
   a_done_follows: assert property (
      st_r.cmp_go
      |=> HDR_DONE_O)
      else $error("done missing after compare start");
   a_done_only: assert property (
      !st_r.cmp_go
      |=> !HDR_DONE_O)
      else $error("done without compare start");
   a_match_hold: assert property (
      !st_r.cmp_go
      |=> $stable(HDR_MATCH_O))
      else $error("match result moved between compares");
   a_var_len_out: assert property (
      !FIX_LEN_I
      |=> RX_LEN_O == st_r.len)
      else $error("variable length not reported");

   // state seen right after reset is released
   a_reset_outputs: assert property (
      $fell(RST_I)
      |-> !PREADY_O && !PSLVERR_O && PRDATA_O == 32'h0000_0000
         && RX_LEN_O == rhc_pkg::LEN_RST && !HDR_DONE_O && !HDR_MATCH_O)
      else $error("outputs not at reset values");
   a_reset_masks: assert property (
      $fell(RST_I)
      |-> st_r.mask1 == rhc_pkg::MASK_RST && st_r.mask0 == rhc_pkg::MASK_RST)
      else $error("masks not zero after reset");
   a_reset_hdr: assert property (
      $fell(RST_I)
      |-> st_r.hdr == rhc_pkg::HDR_RST)
      else $error("header not cleared by reset");
endmodule

// *** sim/rhc_regs_bench.sv ***
// self-checking bench for the receive header capture register bank
module rhc_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pw = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic perr;
   logic er;
   logic hv = 1'b0;
   logic lv = 1'b0;
   logic fix = 1'b0;
   logic chk_en = 1'b1;
   logic done;
   logic match;
   logic [1:0] hi = 2'h0;
   logic [7:0] hb = 8'h00;
   logic [7:0] lb = 8'h00;
   logic [7:0] plen = 8'h40;
   logic [7:0] rxlen;
   logic [15:0] mhi = 16'hFFFF;
   int bad_count = 0;
   int n_compared = 0;

   rhc_regs rhc_regs_i (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pw), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(perr), .RX_HDR_VALID_I(hv), .RX_HDR_IDX_I(hi), .RX_HDR_BYTE_I(hb),
      .RX_LEN_VALID_I(lv), .RX_LEN_BYTE_I(lb), .FIX_LEN_I(fix), .PROG_LEN_I(plen),
      .HDR_CHK_EN_I(chk_en), .CHK_HDR_I(32'hA5C3_0F96), .HDR_MASK_HI_I(mhi),
      .RX_LEN_O(rxlen), .HDR_DONE_O(done), .HDR_MATCH_O(match));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // master holds the request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pw <= w;
      pa <= {2'h0, ix, 2'h0};
      pwd <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         bad_count++;
         $display("CHECK FAILED pready expected 1 seen %b", pready);
      end
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic rdchk(input string nm, input logic [7:0] ix, input logic [31:0] e);
      apb(1'b0, ix, 32'h0);
      chk(nm, e, rd);
   endtask

   task automatic rxb(input logic [1:0] i, input logic [7:0] b);
      @(posedge clk);
      hv <= 1'b1;
      hi <= i;
      hb <= b;
      @(posedge clk);
      hv <= 1'b0;
   endtask

   task automatic lenb(input logic [7:0] b);
      @(posedge clk);
      lv <= 1'b1;
      lb <= b;
      @(posedge clk);
      lv <= 1'b0;
   endtask

   // byte 3 goes on air first; byte 0 closes the header and starts the compare
   task automatic pkt(input logic [31:0] h, input logic e);
      int n;
      n = 0;
      for (int k = 3; k >= 0; k--) rxb(k[1:0], h[8*k+:8]);
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'b1 && n < 8);
      chk("hdr_done", 32'h1, {31'h0, done});
      chk("hdr_match", {31'h0, e}, {31'h0, match});
   endtask

   task automatic t_reset();
      for (int k = 8'h45; k <= 8'h4B; k++) rdchk("reset", 8'(k), k == 8'h4B ? 32'hFF : 32'h0);
      chk("rx_len_o", 32'hFF, {24'h0, rxlen});
   endtask

   task automatic t_regs();
      apb(1'b1, rhc_pkg::IDX_MASK1, 32'h5A);
      apb(1'b1, rhc_pkg::IDX_MASK0, 32'hA5);
      apb(1'b1, rhc_pkg::IDX_RXLEN, 32'h00);
      apb(1'b1, rhc_pkg::IDX_HDR2, 32'h77);
      rdchk("mask1", rhc_pkg::IDX_MASK1, 32'h5A);
      rdchk("mask0", rhc_pkg::IDX_MASK0, 32'hA5);
      rdchk("rxlen_ro", rhc_pkg::IDX_RXLEN, 32'hFF);
      rdchk("hdr2_ro", rhc_pkg::IDX_HDR2, 32'h00);
      rdchk("unmapped", 8'h50, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
   endtask

   task automatic t_hdr();
      apb(1'b1, rhc_pkg::IDX_MASK1, 32'hFF);
      apb(1'b1, rhc_pkg::IDX_MASK0, 32'hFE);
      pkt(32'hA5C3_0F97, 1'b1);
      for (int k = 0; k < 4; k++) rdchk("hdr", 8'(8'h47 + k), 32'((32'hA5C3_0F97 >> (24 - 8*k)) & 32'hFF));
      apb(1'b1, rhc_pkg::IDX_MASK0, 32'hFF);
      pkt(32'h5AC3_0F97, 1'b0);
      rdchk("hdr3_new", rhc_pkg::IDX_HDR3, 32'h5A);
      chk_en <= 1'b0;
      pkt(32'h5AC3_0F97, 1'b1);
      chk_en <= 1'b1;
   endtask

   task automatic t_len();
      lenb(8'h3C);
      rdchk("rxlen_var", rhc_pkg::IDX_RXLEN, 32'h3C);
      chk("rx_len_o_var", 32'h3C, {24'h0, rxlen});
      fix <= 1'b1;
      lenb(8'h12);
      rdchk("rxlen_fix", rhc_pkg::IDX_RXLEN, 32'h3C);
      chk("rx_len_o_fix", 32'h40, {24'h0, rxlen});
      fix <= 1'b0;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_hdr();
      t_len();
      // second reset in mid-run must bring every register back
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      wrap_up();
   end

   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
endmodule
